// ===== design/key_wake_pkg.sv
// Purpose: constants shared by the key wake-up input configuration block
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: byte address of a register is four times its index
//
// Behaviour
// - Config bit 7 picks pull-up mode: 0 static, 1 dynamic.
// - Config bits 6..4 pick low, high, falling, rising or both edges.
// - Config bit 0 enables the channel key interrupt input.
// - Reset clears bits 7 and 0, field resets to falling edge code.
`default_nettype none

package key_wake_pkg;

  // ==========================================================
  // register indices and byte addresses
  localparam logic [31:0] IDX_CFG_CH6 = 32'hFFFF_F366;
  localparam logic [31:0] IDX_CFG_CH7 = 32'hFFFF_F367;
  localparam logic [31:0] IDX_STATUS = 32'hFFFF_F370;
  localparam logic [31:0] IDX_MASK = 32'hFFFF_F371;
  localparam logic [31:0] IDX_KEYS = 32'hFFFF_F372;
  localparam logic [31:0] ADDR_CFG_CH6 = IDX_CFG_CH6 << 2;
  localparam logic [31:0] ADDR_CFG_CH7 = IDX_CFG_CH7 << 2;
  localparam logic [31:0] ADDR_STATUS = IDX_STATUS << 2;
  localparam logic [31:0] ADDR_MASK = IDX_MASK << 2;
  localparam logic [31:0] ADDR_KEYS = IDX_KEYS << 2;

  // ==========================================================
  // channel config fields
  localparam int NUM_CH = 2;
  localparam int CFG_PULL_BIT = 7;
  localparam int CFG_COND_LSB = 4;
  localparam int CFG_EN_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h20;
  localparam logic [7:0] CFG_WMASK = 8'hF1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ==========================================================
  // active condition codes
  typedef enum logic [2:0] {
    COND_LOW = 3'h0,
    COND_HIGH = 3'h1,
    COND_FALL = 3'h2,
    COND_RISE = 3'h3,
    COND_BOTH = 3'h4
  } cond_t;

  // ==========================================================
  // bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : key_wake_pkg

`default_nettype wire

// ===== design/key_cond_detect.sv
// Purpose: detects the programmed active condition on one key input
// Assumes: key input synchronous to clock_i
// Notes: hit_o is registered, one cycle after the qualifying sample
`timescale 1ns/10ps
`default_nettype none

module key_cond_detect
  import key_wake_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic key_i,
  input wire logic enable_i,
  input wire logic [2:0] cond_i,
  output logic hit_o
);

  // ==========================================================
  // edge history
  logic prev_q;
  logic primed_q;
  logic hit_q;
  wire logic rise_w;
  wire logic fall_w;
  wire logic hit_d;

  assign rise_w = primed_q && key_i && !prev_q;
  assign fall_w = primed_q && !key_i && prev_q;

  // ==========================================================
  // condition select
  assign hit_d = enable_i && (
    (cond_i == COND_LOW) ? !key_i :
    (cond_i == COND_HIGH) ? key_i :
    (cond_i == COND_FALL) ? fall_w :
    (cond_i == COND_RISE) ? rise_w :
    (cond_i == COND_BOTH) ? (rise_w || fall_w) : 1'b0);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
      primed_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      prev_q <= key_i;
      primed_q <= 1'b1;
      hit_q <= hit_d;
    end
  end

  assign hit_o = hit_q;

  // ==========================================================
  // checks
  AST_FALL_HIT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && cond_i == COND_FALL && primed_q && prev_q && !key_i |=> hit_o)
    else $error("falling edge missed");
  AST_BOTH_HIT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && cond_i == COND_BOTH && primed_q && (prev_q != key_i) |=> hit_o)
    else $error("edge missed in both-edge mode");
  AST_EN_GATE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !enable_i |=> !hit_o)
    else $error("hit while disabled");

endmodule : key_cond_detect

`default_nettype wire

// ===== design/key_wakeup_input_config.sv
// Purpose: key wake-up config registers for two channels with AHB-Lite access
// Assumes: single-word transfers, zero wait states, inputs synchronous
// Notes: status bits are sticky, cleared by writing one
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module key_wakeup_input_config
  import key_wake_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic key_input_ch6_i,
  input wire logic key_input_ch7_i,
  output logic pullup_mode_ch6_o,
  output logic pullup_mode_ch7_o,
  output logic key_irq_ch6_o,
  output logic key_irq_ch7_o,
  output logic irq_o
);

  // ==========================================================
  // state
  logic [7:0] cfg_q [NUM_CH];
  logic [NUM_CH-1:0] stat_q;
  logic [NUM_CH-1:0] mask_q;
  logic [31:0] rdata_q;
  logic wr_q;
  logic [31:0] wr_addr_q;
  wire logic [NUM_CH-1:0] key_w;
  wire logic [NUM_CH-1:0] hit_w;

  assign key_w = {key_input_ch7_i, key_input_ch6_i};

  // ==========================================================
  // address phase decode
  wire logic addr_ph_w;
  wire logic rd_go_w;
  wire logic [31:0] rd_val_w;
  wire logic [31:0] cfg6_rd_w;
  wire logic [31:0] cfg7_rd_w;

  assign addr_ph_w = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
  assign rd_go_w = addr_ph_w && !hwrite_i;
  assign cfg6_rd_w = {24'h00_0000, cfg_q[0] & CFG_WMASK};
  assign cfg7_rd_w = {24'h00_0000, cfg_q[1] & CFG_WMASK};
  assign rd_val_w =
    (haddr_i == ADDR_CFG_CH6) ? cfg6_rd_w :
    (haddr_i == ADDR_CFG_CH7) ? cfg7_rd_w :
    (haddr_i == ADDR_STATUS) ? {30'h0000_0000, stat_q} :
    (haddr_i == ADDR_MASK) ? {30'h0000_0000, mask_q} :
    (haddr_i == ADDR_KEYS) ? {30'h0000_0000, key_w} : 32'h0000_0000;

  // ==========================================================
  // data phase decode
  wire logic wr_cfg6_w;
  wire logic wr_cfg7_w;
  wire logic wr_stat_w;
  wire logic wr_mask_w;
  wire logic [7:0] wr_cfg_val_w;

  assign wr_cfg6_w = wr_q && (wr_addr_q == ADDR_CFG_CH6);
  assign wr_cfg7_w = wr_q && (wr_addr_q == ADDR_CFG_CH7);
  assign wr_stat_w = wr_q && (wr_addr_q == ADDR_STATUS);
  assign wr_mask_w = wr_q && (wr_addr_q == ADDR_MASK);
  assign wr_cfg_val_w = hwdata_i[7:0] & CFG_WMASK;

  // ==========================================================
  // bus pipeline
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= addr_ph_w && hwrite_i;
      wr_addr_q <= haddr_i;
      rdata_q <= rd_go_w ? rd_val_w : 32'h0000_0000;
    end
  end

  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = HRESP_OKAY;

  // ==========================================================
  // channel config registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cfg_q[0] <= CFG_RESET;
      cfg_q[1] <= CFG_RESET;
    end else begin
      if (wr_cfg6_w) begin
        cfg_q[0] <= wr_cfg_val_w;
      end
      if (wr_cfg7_w) begin
        cfg_q[1] <= wr_cfg_val_w;
      end
    end
  end

  assign pullup_mode_ch6_o = cfg_q[0][CFG_PULL_BIT];
  assign pullup_mode_ch7_o = cfg_q[1][CFG_PULL_BIT];

  // ==========================================================
  // per-channel detectors
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      key_cond_detect u_det (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .key_i(key_w[ch]),
        .enable_i(cfg_q[ch][CFG_EN_BIT]),
        .cond_i(cfg_q[ch][CFG_COND_LSB +: 3]),
        .hit_o(hit_w[ch])
      );
    end
  endgenerate

  assign key_irq_ch6_o = hit_w[0];
  assign key_irq_ch7_o = hit_w[1];

  // ==========================================================
  // sticky status and mask
  wire logic [NUM_CH-1:0] stat_clr_w;
  wire logic [NUM_CH-1:0] stat_d;

  assign stat_clr_w = wr_stat_w ? hwdata_i[NUM_CH-1:0] : 2'h0;
  assign stat_d = (stat_q & ~stat_clr_w) | hit_w;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      stat_q <= IRQ_RESET;
      mask_q <= IRQ_RESET;
    end else begin
      stat_q <= stat_d;
      if (wr_mask_w) begin
        mask_q <= hwdata_i[NUM_CH-1:0];
      end
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ==========================================================
  // checks
  AST_PULL_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_cfg6_w |=> pullup_mode_ch6_o == $past(hwdata_i[CFG_PULL_BIT]))
    else $error("pull-up mode not taken from write");
  AST_RESET_VAL: assert property (@(posedge clock_i)
    !rst_n_i |=> cfg_q[0] == CFG_RESET && cfg_q[1] == CFG_RESET)
    else $error("config reset value wrong");
  AST_STAT_SET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    hit_w[1] |=> stat_q[1] && (irq_o == mask_q[1] || stat_q[0]))
    else $error("status not set by event");
  AST_UNUSED_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_go_w && haddr_i == ADDR_CFG_CH7 |=> hrdata_o[3:1] == 3'h0)
    else $error("unused config bits not zero");
  AST_UNUSED_ZERO6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_go_w && haddr_i == ADDR_CFG_CH6
    |=> hrdata_o[3:1] == 3'h0)
    else $error("unused config bits not zero on channel 6");

  // ==========================================================
  // read path checks
  AST_RDATA_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !rd_go_w
    |=> hrdata_o == 32'h0000_0000)
    else $error("read data not zero outside a read");
  AST_RD_UPPER_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_go_w
    |=> hrdata_o[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");
  AST_RD_CFG6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_go_w && haddr_i == ADDR_CFG_CH6
    |=> hrdata_o[7:0] == ($past(cfg_q[0]) & CFG_WMASK))
    else $error("channel 6 config read wrong");
  AST_RD_STAT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_go_w && haddr_i == ADDR_STATUS
    |=> hrdata_o[NUM_CH-1:0] == $past(stat_q))
    else $error("status read wrong");
  AST_RD_MASK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_go_w && haddr_i == ADDR_MASK
    |=> hrdata_o[NUM_CH-1:0] == $past(mask_q))
    else $error("mask read wrong");
  AST_RD_KEYS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_go_w && haddr_i == ADDR_KEYS
    |=> hrdata_o[NUM_CH-1:0] == $past(key_w))
    else $error("key level read wrong");

  // ==========================================================
  // config write checks
  AST_PULL_WRITE7: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_cfg7_w
    |=> pullup_mode_ch7_o == $past(hwdata_i[CFG_PULL_BIT]))
    else $error("channel 7 pull-up mode not taken from write");
  AST_COND_WRITE6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_cfg6_w
    |=> cfg_q[0][CFG_COND_LSB +: 3] == $past(hwdata_i[CFG_COND_LSB +: 3]))
    else $error("channel 6 condition not taken from write");
  AST_COND_WRITE7: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_cfg7_w
    |=> cfg_q[1][CFG_COND_LSB +: 3] == $past(hwdata_i[CFG_COND_LSB +: 3]))
    else $error("channel 7 condition not taken from write");
  AST_EN_WRITE6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_cfg6_w
    |=> cfg_q[0][CFG_EN_BIT] == $past(hwdata_i[CFG_EN_BIT]))
    else $error("channel 6 enable not taken from write");
  AST_EN_WRITE7: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_cfg7_w
    |=> cfg_q[1][CFG_EN_BIT] == $past(hwdata_i[CFG_EN_BIT]))
    else $error("channel 7 enable not taken from write");
  AST_CFG_HOLD6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !wr_cfg6_w
    |=> $stable(cfg_q[0]))
    else $error("channel 6 config changed without write");
  AST_CFG_HOLD7: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !wr_cfg7_w
    |=> $stable(cfg_q[1]))
    else $error("channel 7 config changed without write");
  AST_CFG_SPARE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_q[0][3:1] == 3'h0
    && cfg_q[1][3:1] == 3'h0)
    else $error("unused config bits stored");

  // ==========================================================
  // reset checks
  AST_RESET_OUT: assert property (@(posedge clock_i)
    !rst_n_i
    |=> !pullup_mode_ch6_o && !pullup_mode_ch7_o && !irq_o && stat_q == 2'h0 && mask_q == 2'h0)
    else $error("outputs not cleared by reset");
  AST_RESET_HIT: assert property (@(posedge clock_i)
    !rst_n_i
    |=> hit_w == 2'h0)
    else $error("channel request during reset");

  // ==========================================================
  // event, status and mask checks
  AST_EN_OFF6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !cfg_q[0][CFG_EN_BIT]
    |=> !key_irq_ch6_o)
    else $error("channel 6 request while disabled");
  AST_EN_OFF7: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !cfg_q[1][CFG_EN_BIT]
    |=> !key_irq_ch7_o)
    else $error("channel 7 request while disabled");
  AST_ILLEGAL6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_q[0][CFG_COND_LSB +: 3] > 3'h4
    |=> !key_irq_ch6_o)
    else $error("channel 6 request on unused condition code");
  AST_ILLEGAL7: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_q[1][CFG_COND_LSB +: 3] > 3'h4
    |=> !key_irq_ch7_o)
    else $error("channel 7 request on unused condition code");
  AST_STAT_SET6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    hit_w[0]
    |=> stat_q[0])
    else $error("channel 6 status not set by event");
  AST_STAT_CLR6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_stat_w && hwdata_i[0] && !hit_w[0]
    |=> !stat_q[0])
    else $error("channel 6 status not cleared");
  AST_STAT_CLR7: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_stat_w && hwdata_i[1] && !hit_w[1]
    |=> !stat_q[1])
    else $error("channel 7 status not cleared");
  AST_STAT_HOLD6: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !hit_w[0] && !(wr_stat_w && hwdata_i[0])
    |=> stat_q[0] == $past(stat_q[0]))
    else $error("channel 6 status changed without cause");
  AST_STAT_HOLD7: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !hit_w[1] && !(wr_stat_w && hwdata_i[1])
    |=> stat_q[1] == $past(stat_q[1]))
    else $error("channel 7 status changed without cause");
  AST_MASK_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_mask_w
    |=> mask_q == $past(hwdata_i[NUM_CH-1:0]))
    else $error("mask not taken from write");
  AST_MASK_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !wr_mask_w
    |=> $stable(mask_q))
    else $error("mask changed without write");
  AST_IRQ_SET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (stat_q[0] && mask_q[0]) || (stat_q[1] && mask_q[1])
    |-> irq_o)
    else $error("interrupt low with unmasked status");
  AST_IRQ_QUIET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (stat_q & mask_q) == 2'h0
    |-> !irq_o)
    else $error("interrupt high without unmasked status");

endmodule : key_wakeup_input_config

`default_nettype wire

// ===== tb/key_switch_model.sv
// Purpose: key and switch pins seen by the wake-up block
// Assumes: keys settle before the block samples them
// Notes: levels follow the bench command one cycle later
`timescale 1ns/10ps
`default_nettype none

module key_switch_model (
  input wire logic clock_i,
  input wire logic [1:0] level_i,
  output logic key_ch6_o = 1'b1,
  output logic key_ch7_o = 1'b1
);
  // ==========================================================
  // pin drive, idle high
  always @(posedge clock_i) begin
    key_ch6_o <= level_i[0];
    key_ch7_o <= level_i[1];
  end
endmodule : key_switch_model

`default_nettype wire

// ===== tb/key_wakeup_input_config_test.sv
// Purpose: self-checking bench for the key wake-up config block
// Assumes: zero or more wait states, OKAY responses
// Notes: condition sweep per channel, then status, mask and reset
`timescale 1ns/10ps
`default_nettype none

module key_wakeup_input_config_test;
  import key_wake_pkg::*;
  logic clock = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0, lv = 2'h3;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, a;
  wire logic [31:0] hrdata;
  wire logic rdy, resp, pu6, pu7, ki6, ki7, irq, k6, k7;
  logic k1, k2, kw, ko;
  int fail_count = 0, check_count = 0, cyc = 0;
  logic [15:0] rows [7] = '{16'h0101, 16'h1111, 16'h2121, 16'h3131,
                            16'hC1C1, 16'h4040, 16'hFFF1};
  logic [7:0] pat = 8'h69;

  always #10 clock = ~clock;

  key_switch_model ksm (.clock_i(clock), .level_i(lv), .key_ch6_o(k6), .key_ch7_o(k7));
  key_wakeup_input_config uut (.clock_i(clock), .rst_n_i(rst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy),
    .hresp_o(resp), .key_input_ch6_i(k6), .key_input_ch7_i(k7),
    .pullup_mode_ch6_o(pu6), .pullup_mode_ch7_o(pu7), .key_irq_ch6_o(ki6),
    .key_irq_ch7_o(ki7), .irq_o(irq));

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [2:0] c, input logic p, input logic k);
    case (c)
      3'h0: hit = !k;
      3'h1: hit = k;
      3'h2: hit = p & !k;
      3'h3: hit = !p & k;
      3'h4: hit = p ^ k;
      default: hit = 1'b0;
    endcase
  endfunction : hit

  task automatic fail(input string m);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) fail($sformatf("data %h expected %h", g, e));
  endtask : chk32

  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e) fail($sformatf("bit %b expected %b", g, e));
  endtask : chk1

  task automatic bus(input logic [31:0] ad, input logic w, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (rdy !== 1'b1);
    rd = hrdata;
    chk1(resp, HRESP_OKAY);
  endtask : bus

  task automatic pulse6;
    @(posedge clock);
    lv <= 2'h2;
    @(posedge clock);
    lv <= 2'h3;
    repeat (5) @(posedge clock);
    #1;
  endtask : pulse6

  task automatic reset_chk;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    bus(ADDR_CFG_CH6, 1'b0, 32'h0);
    chk32(rd, 32'h20);
    bus(ADDR_CFG_CH7, 1'b0, 32'h0);
    chk32(rd, 32'h20);
    chk1(pu6 | pu7 | irq, 1'b0);
    $display("reset test done");
  endtask : reset_chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // tests
  initial begin
    reset_chk();
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 7; i++) begin
        a = ch ? ADDR_CFG_CH7 : ADDR_CFG_CH6;
        bus(a, 1'b1, {24'h0, rows[i][15:8]});
        bus(a, 1'b0, 32'h0);
        chk32(rd, {24'h0, rows[i][7:0]});
        chk1(ch ? pu7 : pu6, rows[i][15]);
        k1 = 1'b1;
        k2 = 1'b1;
        for (int t = 0; t < 10; t++) begin
          @(posedge clock);
          lv[ch] <= (t < 8) ? pat[t] : 1'b1;
          #1;
          kw = ch ? k7 : k6;
          ko = ch ? ki7 : ki6;
          chk1(ko, hit(rows[i][14:12], k2, k1) & rows[i][8]);
          k2 = k1;
          k1 = kw;
        end
      end
      $display("condition test done");
    end
    bus(ADDR_CFG_CH6, 1'b1, 32'h21);
    bus(ADDR_MASK, 1'b1, 32'h1);
    bus(ADDR_STATUS, 1'b1, 32'h3);
    pulse6();
    chk1(irq, 1'b1);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    chk32(rd, 32'h1);
    bus(ADDR_STATUS, 1'b1, 32'h1);
    #1;
    chk1(irq, 1'b0);
    bus(ADDR_MASK, 1'b1, 32'h0);
    pulse6();
    chk1(irq, 1'b0);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    chk32(rd, 32'h1);
    bus(ADDR_KEYS, 1'b0, 32'h0);
    chk32(rd, 32'h3);
    bus(ADDR_KEYS + 32'h4, 1'b0, 32'h0);
    chk32(rd, 32'h0);
    $display("status test done");
    reset_chk();
    give_verdict();
  end
endmodule : key_wakeup_input_config_test

`default_nettype wire
